// ==== core/vcd_pkg.sv ====
/*
 * Shared constants for the video clock divider and demodulation delay block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a single clock domain; aclk stands in for the 96 MHz PLL clock.
 */
package vcd_pkg;
    // Register byte offsets on the AXI4-Lite slave
    localparam logic [3:0] VCD_OFS_DIV_CFG  = 4'h0;  // video_clock_divider_config
    localparam logic [3:0] VCD_OFS_DMD_DLY  = 4'h4;  // demod_path_delay
    localparam logic [3:0] VCD_OFS_STATUS   = 4'h8;  // applied settings, read only
    // Divider config fields
    localparam int         VCD_DIV_LSB      = 0;
    localparam int         VCD_DIV_W        = 5;
    localparam int         VCD_SKEW_BIT     = 7;
    localparam logic [4:0] VCD_DIV_RESET    = 5'h03;  // 96 MHz / 4 = 24 MHz
    localparam logic [4:0] VCD_DIV_MIN      = 5'h01;  // 48 MHz
    localparam logic [4:0] VCD_DIV_MAX      = 5'h1f;  // 3 MHz
    // Demodulation delay
    localparam logic [7:0] VCD_DLY_RESET    = 8'h00;
    localparam int         VCD_DLY_MAX      = 12;
    localparam int         VCD_DLY_W        = 4;
    // Status fields
    localparam int         VCD_ST_DLY_LSB   = 0;
    localparam int         VCD_ST_DIV_LSB   = 8;
    localparam int         VCD_ST_CLK_BIT   = 16;
    // Timing: the skew delay in ns against the clock period
    localparam int         VCD_CLK_PERIOD_NS = 100;
    localparam int         VCD_SKEW_NS       = 2;
    localparam int         VCD_SKEW_CYC_RAW  =
        (VCD_SKEW_NS + VCD_CLK_PERIOD_NS - 1) / VCD_CLK_PERIOD_NS;
    localparam int         VCD_SKEW_CYC      = (VCD_SKEW_CYC_RAW < 1) ? 1 : VCD_SKEW_CYC_RAW;
    // AXI responses
    localparam logic [1:0] VCD_RESP_OKAY    = 2'h0;
    localparam logic [1:0] VCD_RESP_SLVERR  = 2'h2;
endpackage

// ==== core/vcd_dly_if.sv ====
/*
 * Carrier between the top module and the demodulation delay line.
 * Assumes both ends sit on the same clock.
 */
interface vcd_dly_if #(parameter int SEL_W = 4);
    logic             sample_in;  // Demodulation signal entering the line
    logic [SEL_W-1:0] sel;        // Applied delay in clocks
    logic             tap;        // Selected delayed sample
    modport ctrl (output sample_in, output sel, input tap);
    modport line (input sample_in, input sel, output tap);
endinterface

// ==== core/vcd_delay_line.sv ====
/*
 * Tapped shift register for the demodulation path.
 * Assumes sel never exceeds MAX_DLY; the top clamps it.
 */
module vcd_delay_line #(
    parameter int MAX_DLY = 12
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    vcd_dly_if.line   dl
);
    import vcd_pkg::*;

    logic [MAX_DLY:1] hist_q;  // hist_q[k] holds the input from k clocks ago
    logic [MAX_DLY:1] hist_d;

    // Refuse at elaboration a depth that the tap select cannot address
    if (MAX_DLY < 1 || MAX_DLY >= (1 << $bits(dl.sel))) begin : g_bad_depth
        $error("vcd_delay_line: MAX_DLY does not fit sel");
    end

    // Shift by one stage per clock; delay is pure counted periods, no analog part
    always_comb begin
        hist_d[1] = dl.sample_in;
    end
    for (genvar k = 2; k <= MAX_DLY; k++) begin : g_stage
        always_comb begin
            hist_d[k] = hist_q[k-1];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hist_q <= '0;
        end else begin
            hist_q <= hist_d;
        end
    end

    // Tap zero bypasses the line entirely
    always_comb begin
        if (dl.sel == '0) begin
            dl.tap = dl.sample_in;
        end else begin
            dl.tap = hist_q[dl.sel];
        end
    end
endmodule

// ==== core/vcd_top.sv ====
/*
 * Video pixel clock divider with edge skew, plus programmable demodulation
 * path delay, both configured over an AXI4-Lite slave.
 * Assumes aclk is the PLL clock and demod_in comes from logic on aclk.
 */
// Function
// - Pixel clock is PLL clock over divider+1
// - Divider resets to 3, 24 MHz
// - Skew enable delays pixel clock edge
// - Without skew, clock edge centred on data
// - Demod path delayed by programmed periods
// - Zero means none, n means n clocks, plus one output register clock
// - Each delay step is one PLL period
// - Delay from counted clocks, temperature independent
module vcd_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        demod_in,
    output logic             demod_out,
    output logic             video_pixel_clock_out,
    output logic             video_launch
);
    import vcd_pkg::*;

    // Register file
    logic [7:0]  div_cfg_q, div_cfg_d;     // video_clock_divider_config
    logic [7:0]  dly_cfg_q, dly_cfg_d;     // demod_path_delay
    // AXI write side
    logic        aw_have_q, aw_have_d;     // Address held, waiting for data
    logic [3:0]  aw_addr_q, aw_addr_d;
    logic        w_have_q, w_have_d;       // Data held, waiting for address
    logic [31:0] w_data_q, w_data_d;
    logic        w_strb0_q, w_strb0_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    // AXI read side
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;
    // Ready flags kept as flops so every port comes straight from a register
    logic        awrdy_q, awrdy_d;
    logic        wrdy_q, wrdy_d;
    logic        arrdy_q, arrdy_d;
    // Divider
    logic [4:0]  cnt_q, cnt_d;             // Position within one pixel clock period
    logic [4:0]  div_eff_q, div_eff_d;     // Divider in force for this period
    logic        clk_pre_q, clk_pre_d;     // Unskewed clock, one stage early
    logic        vclk_q, vclk_d;
    logic        launch_q, launch_d;
    // Demod
    logic        dmd_q, dmd_d;
    logic [3:0]  dly_app;                  // Clamped delay
    logic [4:0]  div_req, half;
    logic        raw_clk;

    vcd_dly_if #(.SEL_W(VCD_DLY_W)) dl_if ();

    vcd_delay_line #(.MAX_DLY(VCD_DLY_MAX)) u_line (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dl      (dl_if.line)
    );

    // Refuse at elaboration a skew that the single extra stage cannot serve
    if (VCD_SKEW_CYC != 1) begin : g_bad_skew
        $error("vcd_top: skew stage supports exactly one clock");
    end

    // Clamp the delay so an oversized write still lands on the longest tap
    always_comb begin
        if (dly_cfg_q > 8'(VCD_DLY_MAX)) begin
            dly_app = 4'(VCD_DLY_MAX);
        end else begin
            dly_app = dly_cfg_q[3:0];
        end
        dl_if.sample_in = demod_in;
        dl_if.sel       = dly_app;
        dmd_d           = dl_if.tap;
    end

    // Divider request; 0 would give no clock at all, so it is served as 1
    always_comb begin
        div_req = div_cfg_q[VCD_DIV_LSB +: VCD_DIV_W];
        if (div_req < VCD_DIV_MIN) begin
            div_req = VCD_DIV_MIN;
        end
        half    = 5'((6'(div_eff_q) + 6'h01) >> 1);
        raw_clk = (cnt_q >= half);
    end

    // Counter wraps at div_eff; a new divider only takes hold at the wrap,
    // so only a write that sets or clears the skew bit can produce a runt pulse on the pixel clock
    always_comb begin
        div_eff_d = div_eff_q;
        if (cnt_q >= div_eff_q) begin
            cnt_d     = 5'h00;
            div_eff_d = div_req;
        end else begin
            cnt_d = cnt_q + 5'h01;
        end
        // Data launches at count 0, clock rises mid-window
        launch_d  = (cnt_q == 5'h00);
        clk_pre_d = raw_clk;
        // Skew adds one stage; a fine 2 ns trim is not possible in clocked logic
        if (div_cfg_q[VCD_SKEW_BIT]) begin
            vclk_d = clk_pre_q;
        end else begin
            vclk_d = raw_clk;
        end
    end

    // AXI write path: address and data accepted in either order
    always_comb begin
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d  = w_have_q;
        w_data_d  = w_data_q;
        w_strb0_d = w_strb0_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        div_cfg_d = div_cfg_q;
        dly_cfg_d = dly_cfg_q;
        if (s_axi_awvalid && !aw_have_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_q) begin
            w_have_d  = 1'b1;
            w_data_d  = s_axi_wdata;
            w_strb0_d = s_axi_wstrb[0];
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // Commit once both halves are held and no response is pending
        if (aw_have_q && w_have_q && !bvalid_q) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = VCD_RESP_OKAY;
            case (aw_addr_q)
                VCD_OFS_DIV_CFG: begin
                    if (w_strb0_q) div_cfg_d = w_data_q[7:0];
                end
                VCD_OFS_DMD_DLY: begin
                    if (w_strb0_q) dly_cfg_d = w_data_q[7:0];
                end
                VCD_OFS_STATUS: begin
                    bresp_d = VCD_RESP_OKAY;  // Read-only, write ignored
                end
                default: begin
                    bresp_d = VCD_RESP_SLVERR;
                end
            endcase
        end
        // Ready mirrors the free slots of the next cycle
        awrdy_d = !aw_have_d;
        wrdy_d  = !w_have_d;
    end

    // AXI read path: one cycle from address to data
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d  = VCD_RESP_OKAY;
            rdata_d  = 32'h0000_0000;
            case (s_axi_araddr)
                VCD_OFS_DIV_CFG: rdata_d[7:0] = div_cfg_q;
                VCD_OFS_DMD_DLY: rdata_d[7:0] = dly_cfg_q;
                VCD_OFS_STATUS: begin
                    rdata_d[VCD_ST_DLY_LSB +: 4] = dly_app;
                    rdata_d[VCD_ST_DIV_LSB +: 5] = div_eff_q;
                    rdata_d[VCD_ST_CLK_BIT]      = vclk_q;
                end
                default: rresp_d = VCD_RESP_SLVERR;
            endcase
        end
        arrdy_d = !rvalid_d;
    end

    // All design state registers; the check helper keeps its own
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cfg_q <= {3'h0, VCD_DIV_RESET};
            dly_cfg_q <= VCD_DLY_RESET;
            aw_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_have_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb0_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= VCD_RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= VCD_RESP_OKAY;
            cnt_q     <= 5'h00;
            div_eff_q <= VCD_DIV_RESET;
            clk_pre_q <= 1'b0;
            vclk_q    <= 1'b0;
            launch_q  <= 1'b0;
            dmd_q     <= 1'b0;
            awrdy_q   <= 1'b1;
            wrdy_q    <= 1'b1;
            arrdy_q   <= 1'b1;
        end else begin
            div_cfg_q <= div_cfg_d;
            dly_cfg_q <= dly_cfg_d;
            aw_have_q <= aw_have_d;
            aw_addr_q <= aw_addr_d;
            w_have_q  <= w_have_d;
            w_data_q  <= w_data_d;
            w_strb0_q <= w_strb0_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            cnt_q     <= cnt_d;
            div_eff_q <= div_eff_d;
            clk_pre_q <= clk_pre_d;
            vclk_q    <= vclk_d;
            launch_q  <= launch_d;
            dmd_q     <= dmd_d;
            awrdy_q   <= awrdy_d;
            wrdy_q    <= wrdy_d;
            arrdy_q   <= arrdy_d;
        end
    end

    assign s_axi_awready         = awrdy_q;
    assign s_axi_wready          = wrdy_q;
    assign s_axi_bvalid          = bvalid_q;
    assign s_axi_bresp           = bresp_q;
    assign s_axi_arready         = arrdy_q;
    assign s_axi_rvalid          = rvalid_q;
    assign s_axi_rdata           = rdata_q;
    assign s_axi_rresp           = rresp_q;
    assign demod_out             = dmd_q;
    assign video_pixel_clock_out = vclk_q;
    assign video_launch          = launch_q;

    // Helper: clocks since the last launch, for the period check
    // A new divider is already in force when the launch that closes the
    // old period shows, so the closed period is judged by the stored one
    logic [5:0] per_q;
    logic       seen_q;
    logic [4:0] div_last_q;  // Divider of the period that the next launch closes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            per_q      <= 6'h00;
            seen_q     <= 1'b0;
            div_last_q <= VCD_DIV_RESET;
        end else begin
            per_q      <= launch_q ? 6'h01 : per_q + 6'h01;
            seen_q     <= seen_q | launch_q;
            div_last_q <= launch_q ? div_eff_q : div_last_q;
        end
    end

    property p_div_reset;
        @(posedge aclk) !aresetn |=> (div_cfg_q[4:0] == 5'h03) && (div_eff_q == 5'h03);
    endproperty
    a_div_reset: assert property (p_div_reset) else $error("divider not 3 after reset");

    property p_period;
        @(posedge aclk) disable iff (!aresetn)
            (launch_q && seen_q) |-> (per_q == 6'(div_last_q) + 6'h01);
    endproperty
    a_period: assert property (p_period) else $error("pixel clock period not div+1");

    property p_div_min;
        @(posedge aclk) disable iff (!aresetn) div_eff_q >= 5'h01;
    endproperty
    a_div_min: assert property (p_div_min) else $error("divider in force below 1");

    property p_centre;
        @(posedge aclk) disable iff (!aresetn)
            (launch_q && div_eff_q == 5'h03 && !div_cfg_q[7]) ##1 !div_cfg_q[7]
            ##1 !div_cfg_q[7] |-> $rose(vclk_q);
    endproperty
    a_centre: assert property (p_centre) else $error("clock edge not centred");

    property p_skew;
        @(posedge aclk) disable iff (!aresetn)
            (launch_q && div_eff_q == 5'h03 && div_cfg_q[7]) ##1 div_cfg_q[7]
            ##1 div_cfg_q[7] |-> !vclk_q ##1 $rose(vclk_q);
    endproperty
    a_skew: assert property (p_skew) else $error("skewed edge not one clock late");

    property p_dly_zero;
        @(posedge aclk) disable iff (!aresetn)
            (dly_cfg_q == 8'h00) |=> (demod_out == $past(demod_in));
    endproperty
    a_dly_zero: assert property (p_dly_zero) else $error("zero delay not bypassed");

    property p_dly_max;
        @(posedge aclk) disable iff (!aresetn)
            (dly_cfg_q >= 8'h0c)[*8] ##1 (dly_cfg_q >= 8'h0c)[*6]
            |-> (demod_out == $past(demod_in, 13));
    endproperty
    a_dly_max: assert property (p_dly_max) else $error("delay not clamped to 12");

    property p_dly_five;
        @(posedge aclk) disable iff (!aresetn)
            (dly_cfg_q == 8'h05)[*7] |-> (demod_out == $past(demod_in, 6));
    endproperty
    a_dly_five: assert property (p_dly_five) else $error("delay of 5 clocks wrong");

    property p_bhold;
        @(posedge aclk) disable iff (!aresetn)
            (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule

// ==== testbench/vcd_host_capture.sv ====
/*
 * Host-side capture model: times the pixel clock against the launch marker,
 * as a receiver clocked by aclk would see them.
 * Assumes both inputs are registered design outputs on aclk.
 */
module vcd_host_capture (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic pix_clk,
    input  wire logic launch
);
    timeunit 1ns;
    timeprecision 1ns;
    int   period_cyc;  // Cycles between two launch markers
    int   rise_ofs;    // Cycles from launch to the rising pixel clock
    int   cnt;         // Cycle index since the last launch
    logic pix_prev;    // Previous pixel clock sample
    // Samples once per clock like a capture flop; no edge of its own is trusted
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt = 0;
            pix_prev = 1'b0;
            period_cyc = 0;
            rise_ofs = -1;
        end else begin
            if (launch) begin
                period_cyc = cnt + 1;
                cnt = 0;
            end else begin
                cnt++;
            end
            if (pix_clk && !pix_prev) rise_ofs = cnt;
            pix_prev = pix_clk;
        end
    end
endmodule

// ==== testbench/tb.sv ====
/*
 * Self-checking bench: AXI4-Lite registers, pixel clock timing seen by the
 * capture model, and demod path delay against a queue model.
 * Assumes the watchdog bounds every wait on the slave.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import vcd_pkg::*;
    logic        aclk = 1'b0;      // 10 MHz stand-in for the PLL clock
    logic        aresetn = 1'b0;   // Synchronous, active low
    logic [3:0]  awaddr = 4'h0;
    logic [3:0]  araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;     // Byte enables, cleared for the no-strobe case
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, demod_in = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata, rd;
    logic        demod_out, pix, launch;
    logic        hist[$];          // Past demod_in samples, newest last
    logic [7:0]  cfg;
    int          n_errors = 0;
    int          n_checks = 0;
    int          seed = 87;
    int          i, dmd_n;
    bit          dmd_chk = 0;      // Demod compare only once a setting settled
    logic [7:0]  cfg_tab [6] = '{8'h01, 8'h1f, 8'h83, 8'h9f, 8'he5, 8'h00};

    vcd_top i_vcd_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .demod_in(demod_in),
        .demod_out(demod_out), .video_pixel_clock_out(pix), .video_launch(launch)
    );
    vcd_host_capture i_vcd_host_capture (
        .aclk(aclk), .aresetn(aresetn), .pix_clk(pix), .launch(launch)
    );

    // Free-running clock, 100 ns period
    always #50 aclk = ~aclk;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task complete_run;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Write: both channels offered together, each dropped once taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] re);
        bit awd, wd;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        awd = 0;
        wd = 0;
        do begin
            @(posedge aclk);
            if (!awd && awready) begin
                awd = 1;
                awvalid <= 1'b0;
            end
            if (!wd && wready) begin
                wd = 1;
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1);
        re = bresp;
        bready <= 1'b0;
    endtask

    // Read: rready held until rvalid is sampled high
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] re);
        bit ard;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ard = 0;
        do begin
            @(posedge aclk);
            if (!ard && arready) begin
                ard = 1;
                arvalid <= 1'b0;
            end
        end while (rvalid !== 1'b1);
        d = rdata;
        re = rresp;
        rready <= 1'b0;
    endtask

    // Write, expect OKAY, then read back the stored value
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d, input logic [31:0] e);
        axi_wr(a, d, r);
        check("bresp", {30'h0, r}, {30'h0, VCD_RESP_OKAY});
        axi_rd(a, rd, r);
        check("readback", rd, e);
    endtask

    // Random demod stimulus every cycle once out of reset
    always @(posedge aclk) demod_in <= aresetn ? 1'($random(seed)) : 1'b0;

    // Queue model: output is the input 1 + n cycles earlier
    always @(posedge aclk) begin
        hist.push_back(demod_in);
        if (hist.size() > 40) void'(hist.pop_front());
        if (dmd_chk) check("demod_out", {31'h0, demod_out}, {31'h0, hist[hist.size()-2-dmd_n]});
    end

    // Watchdog, far beyond the ~2000 cycles the sequence needs
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        complete_run;
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(VCD_OFS_DIV_CFG, rd, r);
        check("div reset", rd, 32'h3);
        axi_rd(VCD_OFS_DMD_DLY, rd, r);
        check("delay reset", rd, 32'h0);
        repeat (80) @(posedge aclk);
        check("reset period", 32'(i_vcd_host_capture.period_cyc), 32'd4);
        // Unmapped place refused, status place ignores writes
        axi_rd(4'hc, rd, r);
        check("unmapped rresp", {30'h0, r}, {30'h0, VCD_RESP_SLVERR});
        check("unmapped rdata", rd, 32'h0);
        axi_wr(4'hc, 32'h1, r);
        check("unmapped bresp", {30'h0, r}, {30'h0, VCD_RESP_SLVERR});
        axi_wr(VCD_OFS_STATUS, 32'hffffffff, r);
        check("status bresp", {30'h0, r}, {30'h0, VCD_RESP_OKAY});
        // A write with byte 0 disabled is answered but leaves the divider alone
        wstrb <= 4'h0;
        axi_wr(VCD_OFS_DIV_CFG, 32'h1, r);
        wstrb <= 4'hf;
        check("no-strobe bresp", {30'h0, r}, {30'h0, VCD_RESP_OKAY});
        axi_rd(VCD_OFS_DIV_CFG, rd, r);
        check("no-strobe div", rd, 32'h3);
        axi_rd(VCD_OFS_STATUS, rd, r);
        check("status div", {27'h0, rd[12:8]}, 32'h3);
        // Divider kept within 1..31 by software; skew only where period allows
        for (i = 0; i < 6; i++) begin
            cfg = cfg_tab[i];
            if (i == 5) cfg = {1'($random(seed)), 2'b00, 5'(2 + $unsigned($random(seed)) % 30)};
            wr_reg(VCD_OFS_DIV_CFG, {24'h0, cfg}, {24'h0, cfg});
            repeat (100) @(posedge aclk);
            check("period", 32'(i_vcd_host_capture.period_cyc), 32'(cfg[4:0]) + 1);
            check("rise", 32'(i_vcd_host_capture.rise_ofs), ((32'(cfg[4:0]) + 1) >> 1) + 32'(cfg[7]));
        end
        // Every delay code, then oversized ones that must clamp
        for (i = 0; i < 17; i++) begin
            dmd_n = (i == 16) ? 255 : (i == 15) ? 13 + $unsigned($random(seed)) % 243 : i;
            wr_reg(VCD_OFS_DMD_DLY, 32'(dmd_n), 32'(dmd_n));
            if (dmd_n > 12) dmd_n = 12;
            axi_rd(VCD_OFS_STATUS, rd, r);
            check("status delay", {28'h0, rd[3:0]}, 32'(dmd_n));
            repeat (20) @(posedge aclk);
            dmd_chk = 1;
            repeat (30) @(posedge aclk);
            dmd_chk = 0;
        end
        // A reset in mid-run must bring both settings back to their defaults
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(VCD_OFS_DIV_CFG, rd, r);
        check("div re-reset", rd, 32'h3);
        axi_rd(VCD_OFS_DMD_DLY, rd, r);
        check("delay re-reset", rd, 32'h0);
        repeat (80) @(posedge aclk);
        check("re-reset period", 32'(i_vcd_host_capture.period_cyc), 32'd4);
        complete_run;
    end
endmodule
